// >>> src/scm_compat.sv
// Programmable channel compatibility table, kept apart from the checker
`default_nettype none
module scm_compat (
  input wire logic clk,
  input wire logic reset,
  input wire logic wr_en,
  input wire logic [scm_pkg::ROW_W-1:0] wr_row,
  input wire logic [scm_pkg::NUM_CH-1:0] wr_data,
  output logic [scm_pkg::COMPAT_W-1:0] compat_flat
);
  typedef struct packed {
    logic [scm_pkg::COMPAT_W-1:0] m;
  } scm_compat_s;

  scm_compat_s s_r;
  scm_compat_s s_nxt;

  // ------------------------------------------------------------------
  // Row write
  // ------------------------------------------------------------------
  // All zero at reset: nothing is compatible until programmed, so an
  // unprogrammed unit fails safe into flash on any two active channels
  always_comb begin
    s_nxt = s_r;
    if (wr_en && (wr_row < 4'(scm_pkg::NUM_CH))) begin
      for (int r = 0; r < scm_pkg::NUM_CH; r++) begin
        if (4'(r) == wr_row) begin
          s_nxt.m[r*scm_pkg::NUM_CH +: scm_pkg::NUM_CH] = wr_data;
        end
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign compat_flat = s_r.m;
endmodule : scm_compat
`default_nettype wire

// >>> src/scm_log_mem.sv
// Event log storage with a registered read port
`default_nettype none
module scm_log_mem #(
  parameter int unsigned W = scm_pkg::LOG_W,
  parameter int unsigned DEPTH = scm_pkg::LOG_DEPTH,
  parameter int unsigned AW = scm_pkg::LOG_AW
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [W-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [W-1:0] rd_data
);
  logic [W-1:0] mem [DEPTH];

  // ------------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------------
  // No reset on the array itself so it maps onto block memory
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Read data registered every cycle from the selected slot
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rd_data <= '0;
    end else begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule : scm_log_mem
`default_nettype wire

// >>> src/scm_monitor.sv
// Signal conflict monitor top: checking, fault latch, log and registers
//
// What this block does
// - Supervises twelve signal channels at the same time.
// - Channel n watches red, yellow and green of load switch n.
// - Compatible channel pairs come from a separate programmable table.
// - Any failure or conflict commands the controller into flash.
// - Conflict raises stop-time; the timer halts while it stands.
// - Fault holds until the manual reset button clears it.
// - Voltage monitor failure is latched until reset.
// - Front-panel indicator lights whenever a conflict or failure occurred.
// - At least 99 conflict events logged with date and channels.
// - Voltage monitor and two 24 VDC supply monitors signal failures.
// - Red enable input qualifies checking of red channel outputs.
`default_nettype none
module scm_monitor (
  input wire logic clk,
  input wire logic reset,
  input wire logic [scm_pkg::NUM_CH-1:0] ch_red,
  input wire logic [scm_pkg::NUM_CH-1:0] ch_yellow,
  input wire logic [scm_pkg::NUM_CH-1:0] ch_green,
  input wire logic red_enable,
  input wire logic volt_mon_fail,
  input wire logic dc24_1_fail,
  input wire logic dc24_2_fail,
  input wire logic manual_reset_btn,
  input wire logic [scm_pkg::DATE_W-1:0] tod_date,
  input wire logic [scm_pkg::ADDR_W-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rdata,
  output logic flash_cmd,
  output logic stop_time,
  output logic fault_led,
  output logic monitor_ok,
  output logic irq
);
  localparam int unsigned N = scm_pkg::NUM_CH;

  typedef struct packed {
    logic fault;
    logic [scm_pkg::CAUSE_W-1:0] cause;
    logic [N-1:0] conf_chan;
    logic conf_prev;
    logic btn_prev;
    logic [N-1:0] chan_use;
    logic [scm_pkg::IRQ_W-1:0] irq_stat;
    logic [scm_pkg::IRQ_W-1:0] irq_mask;
    logic [scm_pkg::LOG_AW-1:0] log_idx;
    logic [scm_pkg::LOG_AW-1:0] wr_ptr;
    logic [scm_pkg::CNT_W-1:0] count;
    logic [31:0] rdata;
    logic irq;
    logic alive;
  } scm_state_s;

  scm_state_s s_r;
  scm_state_s s_nxt;

  logic [scm_pkg::COMPAT_W-1:0] compat_flat;
  logic [scm_pkg::LOG_W-1:0] log_rd;
  logic [N-1:0] ch_active;
  logic [N-1:0] conf_set;
  logic [N-1:0] red_fail_set;
  logic [scm_pkg::CAUSE_W-1:0] cause_now;
  logic compat_wr;
  logic [scm_pkg::ROW_W-1:0] compat_row;
  logic log_wr;
  logic [scm_pkg::LOG_W-1:0] log_wdata;

  // ------------------------------------------------------------------
  // Helper functions
  // ------------------------------------------------------------------
  // Channels that sit in at least one incompatible active pair. A pair
  // counts as compatible only if both rows agree, so one bad row entry
  // errs toward flash rather than toward a missed conflict.
  function automatic logic [N-1:0] conflict_set(
    input logic [N-1:0] act,
    input logic [scm_pkg::COMPAT_W-1:0] cm
  );
    logic [N-1:0] hit;
    hit = '0;
    for (int i = 0; i < N; i++) begin
      for (int j = 0; j < N; j++) begin
        if (i != j && act[i] && act[j] &&
            !(cm[i*N+j] && cm[j*N+i])) begin
          hit[i] = 1'b1;
        end
      end
    end
    return hit;
  endfunction : conflict_set

  // Compatibility rows occupy aligned words from the base upward
  function automatic logic is_compat(input logic [scm_pkg::ADDR_W-1:0] a);
    return (a >= scm_pkg::REG_COMPAT_BASE) &&
           (a <= scm_pkg::REG_COMPAT_LAST) && (a[1:0] == 2'h0);
  endfunction : is_compat

  // ------------------------------------------------------------------
  // Channel checking
  // ------------------------------------------------------------------
  // Green or yellow makes a channel active; red is checked separately
  always_comb begin
    ch_active = ch_green | ch_yellow;
    conf_set = conflict_set(ch_active, compat_flat);
    // Dark channel: red is only expected while red enable is applied
    red_fail_set = {N{red_enable}} & s_r.chan_use &
                   ~(ch_red | ch_yellow | ch_green);
    cause_now = '0;
    cause_now[scm_pkg::C_CONFLICT] = |conf_set;
    cause_now[scm_pkg::C_VOLT] = volt_mon_fail;
    cause_now[scm_pkg::C_DC1] = dc24_1_fail;
    cause_now[scm_pkg::C_DC2] = dc24_2_fail;
    cause_now[scm_pkg::C_RED] = |red_fail_set;
  end

  // ------------------------------------------------------------------
  // Bus decode toward the side modules
  // ------------------------------------------------------------------
  assign compat_wr = wr_en && is_compat(addr);
  assign compat_row = 4'(6'(addr[7:2]) - 6'(scm_pkg::REG_COMPAT_BASE[7:2]));

  // One record per conflict onset, stamped with time of day
  assign log_wr = cause_now[scm_pkg::C_CONFLICT] && !s_r.conf_prev;
  assign log_wdata = {tod_date, conf_set};

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb begin
    logic btn_rise;
    logic [scm_pkg::IRQ_W-1:0] ev;
    logic [31:0] rv;
    btn_rise = 1'b0;
    ev = '0;
    rv = '0;
    s_nxt = s_r;
    s_nxt.alive = 1'b1;
    s_nxt.btn_prev = manual_reset_btn;
    s_nxt.conf_prev = cause_now[scm_pkg::C_CONFLICT];
    btn_rise = manual_reset_btn && !s_r.btn_prev;

    // Fault latch: a live cause always wins over the button
    if (|cause_now) begin
      s_nxt.fault = 1'b1;
      s_nxt.cause = s_r.cause | cause_now;
      s_nxt.conf_chan = s_r.conf_chan | conf_set;
      if (!s_r.fault) begin
        ev[scm_pkg::IRQ_FAULT] = 1'b1;
      end
    end else if (btn_rise) begin
      s_nxt.fault = 1'b0;
      s_nxt.cause = '0;
      s_nxt.conf_chan = '0;
    end

    // Circular log: pointer wraps and overwrites the oldest slot
    if (log_wr) begin
      s_nxt.wr_ptr = s_r.wr_ptr + 7'h01;
      if (s_r.count != scm_pkg::LOG_FULL) begin
        s_nxt.count = s_r.count + 8'h01;
      end else begin
        ev[scm_pkg::IRQ_WRAP] = 1'b1;
      end
    end

    // Register writes
    if (wr_en) begin
      case (addr)
        scm_pkg::REG_CHAN_USE: begin
          s_nxt.chan_use = wdata[N-1:0];
        end
        scm_pkg::REG_IRQ_STAT: begin
          s_nxt.irq_stat = s_r.irq_stat & ~wdata[scm_pkg::IRQ_W-1:0];
        end
        scm_pkg::REG_IRQ_MASK: begin
          s_nxt.irq_mask = wdata[scm_pkg::IRQ_W-1:0];
        end
        scm_pkg::REG_LOG_IDX: begin
          s_nxt.log_idx = wdata[scm_pkg::LOG_AW-1:0];
        end
        default: begin
        end
      endcase
    end
    // A new event in the clearing cycle survives the clear
    s_nxt.irq_stat = s_nxt.irq_stat | ev;
    s_nxt.irq = |(s_nxt.irq_stat & s_nxt.irq_mask);

    // Register reads: data only in the cycle after the strobe
    if (rd_en) begin
      case (addr)
        scm_pkg::REG_STATUS: begin
          rv[scm_pkg::CAUSE_W-1:0] = cause_now;
          rv[scm_pkg::ST_FAULT] = s_r.fault;
        end
        scm_pkg::REG_CAUSE: begin
          rv[scm_pkg::CAUSE_W-1:0] = s_r.cause;
        end
        scm_pkg::REG_CONF_CHAN: begin
          rv[N-1:0] = s_r.conf_chan;
        end
        scm_pkg::REG_CHAN_USE: begin
          rv[N-1:0] = s_r.chan_use;
        end
        scm_pkg::REG_IRQ_STAT: begin
          rv[scm_pkg::IRQ_W-1:0] = s_r.irq_stat;
        end
        scm_pkg::REG_IRQ_MASK: begin
          rv[scm_pkg::IRQ_W-1:0] = s_r.irq_mask;
        end
        scm_pkg::REG_LOG_IDX: begin
          rv[scm_pkg::LOG_AW-1:0] = s_r.log_idx;
        end
        scm_pkg::REG_LOG_DATE: begin
          rv = log_rd[scm_pkg::LOG_W-1:N];
        end
        scm_pkg::REG_LOG_CHAN: begin
          rv[N-1:0] = log_rd[N-1:0];
        end
        scm_pkg::REG_LOG_INFO: begin
          rv[scm_pkg::LOG_AW-1:0] = s_r.wr_ptr;
          rv[scm_pkg::INFO_CNT +: scm_pkg::CNT_W] = s_r.count;
        end
        default: begin
          if (is_compat(addr)) begin
            for (int r = 0; r < N; r++) begin
              if (4'(r) == compat_row) begin
                rv[N-1:0] = compat_flat[r*N +: N];
              end
            end
          end
        end
      endcase
    end
    s_nxt.rdata = rv;
  end

  // ------------------------------------------------------------------
  // State register
  // ------------------------------------------------------------------
  // Reset clears the latch too; only a power-up style reset bypasses
  // the button, which is the intent for a cold start
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_r <= '0;
      s_r.chan_use <= scm_pkg::CHAN_USE_RST;
      s_r.irq_mask <= scm_pkg::IRQ_MASK_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ------------------------------------------------------------------
  // Side modules
  // ------------------------------------------------------------------
  scm_compat u_compat (
    .clk(clk),
    .reset(reset),
    .wr_en(compat_wr),
    .wr_row(compat_row),
    .wr_data(wdata[N-1:0]),
    .compat_flat(compat_flat)
  );

  scm_log_mem #(
    .W(scm_pkg::LOG_W),
    .DEPTH(scm_pkg::LOG_DEPTH),
    .AW(scm_pkg::LOG_AW)
  ) u_log (
    .clk(clk),
    .reset(reset),
    .wr_en(log_wr),
    .wr_addr(s_r.wr_ptr),
    .wr_data(log_wdata),
    .rd_addr(s_r.log_idx),
    .rd_data(log_rd)
  );

  // ------------------------------------------------------------------
  // Outputs, all from state flip-flops
  // ------------------------------------------------------------------
  assign flash_cmd = s_r.fault;
  assign stop_time = s_r.fault;
  assign fault_led = s_r.fault;
  // Low in reset so the controller sees a missing monitor as a fault
  assign monitor_ok = s_r.alive;
  assign irq = s_r.irq;
  assign rdata = s_r.rdata;
endmodule : scm_monitor
`default_nettype wire

// >>> src/scm_pkg.sv
// Constants and register map shared by the signal conflict monitor
`default_nettype none
package scm_pkg;
  // ------------------------------------------------------------------
  // Channel and log geometry
  // ------------------------------------------------------------------
  localparam int unsigned NUM_CH = 12;
  localparam int unsigned COMPAT_W = NUM_CH * NUM_CH;
  localparam int unsigned DATE_W = 32;
  localparam int unsigned LOG_W = DATE_W + NUM_CH;
  localparam int unsigned LOG_DEPTH = 128;
  localparam int unsigned LOG_AW = 7;
  localparam int unsigned CNT_W = 8;
  localparam logic [CNT_W-1:0] LOG_FULL = 8'h80;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned ROW_W = 4;

  // ------------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h00;
  localparam logic [ADDR_W-1:0] REG_CAUSE = 8'h04;
  localparam logic [ADDR_W-1:0] REG_CONF_CHAN = 8'h08;
  localparam logic [ADDR_W-1:0] REG_CHAN_USE = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 8'h10;
  localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 8'h14;
  localparam logic [ADDR_W-1:0] REG_LOG_IDX = 8'h18;
  localparam logic [ADDR_W-1:0] REG_LOG_DATE = 8'h1C;
  localparam logic [ADDR_W-1:0] REG_LOG_CHAN = 8'h20;
  localparam logic [ADDR_W-1:0] REG_LOG_INFO = 8'h24;
  localparam logic [ADDR_W-1:0] REG_COMPAT_BASE = 8'h40;
  localparam logic [ADDR_W-1:0] REG_COMPAT_LAST = 8'h6C;

  // ------------------------------------------------------------------
  // Field positions and reset values
  // ------------------------------------------------------------------
  localparam int unsigned CAUSE_W = 5;
  localparam int unsigned C_CONFLICT = 0;
  localparam int unsigned C_VOLT = 1;
  localparam int unsigned C_DC1 = 2;
  localparam int unsigned C_DC2 = 3;
  localparam int unsigned C_RED = 4;
  localparam int unsigned ST_FAULT = 5;
  localparam int unsigned IRQ_W = 2;
  localparam int unsigned IRQ_FAULT = 0;
  localparam int unsigned IRQ_WRAP = 1;
  localparam int unsigned INFO_CNT = 8;
  localparam logic [NUM_CH-1:0] CHAN_USE_RST = 12'hFFF;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 2'h0;
endpackage : scm_pkg
`default_nettype wire

// >>> testbench/scm_monitor_assertions.sv
// Port-level assertions for the signal conflict monitor
`default_nettype none
module scm_monitor_checker (
  input wire logic clk,
  input wire logic reset,
  input wire logic [scm_pkg::NUM_CH-1:0] ch_red,
  input wire logic [scm_pkg::NUM_CH-1:0] ch_yellow,
  input wire logic [scm_pkg::NUM_CH-1:0] ch_green,
  input wire logic red_enable,
  input wire logic volt_mon_fail,
  input wire logic dc24_1_fail,
  input wire logic dc24_2_fail,
  input wire logic manual_reset_btn,
  input wire logic [scm_pkg::ADDR_W-1:0] addr,
  input wire logic rd_en,
  input wire logic [31:0] rdata,
  input wire logic flash_cmd,
  input wire logic stop_time,
  input wire logic fault_led,
  input wire logic monitor_ok
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------------
  // Fault latch and bus checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // Flash, stop time and lamp come from one latch, so never disagree
  outs_tied_a: assert property (stop_time == flash_cmd &&
    fault_led == flash_cmd) else $error("fault outputs disagree");
  cause_latch_a: assert property ((volt_mon_fail || dc24_1_fail ||
    dc24_2_fail) |=> flash_cmd && stop_time)
    else $error("supply failure did not raise flash");
  hold_fault_a: assert property (flash_cmd && !manual_reset_btn
    |=> flash_cmd) else $error("fault dropped without the button");
  // A clear needs the button and no live voltage failure
  clear_cause_a: assert property ($fell(flash_cmd) |->
    $past(manual_reset_btn) && !$past(volt_mon_fail))
    else $error("fault cleared while cause live");
  red_dark_a: assert property (red_enable &&
    (ch_red | ch_yellow | ch_green) == '0 |=> flash_cmd)
    else $error("dark channels not flagged");
  mon_ok_a: assert property (!$past(reset) |-> monitor_ok)
    else $error("monitor_ok low while running");
  rd_idle_a: assert property (!$past(rd_en) |-> rdata == 32'h0)
    else $error("read data outside its cycle");
  unmapped_rd_a: assert property (rd_en && addr == 8'hFC
    |=> rdata == 32'h0) else $error("unmapped read not zero");
endmodule : scm_monitor_checker
bind scm_monitor scm_monitor_checker chk (.clk(clk), .reset(reset),
  .ch_red(ch_red), .ch_yellow(ch_yellow), .ch_green(ch_green),
  .red_enable(red_enable), .volt_mon_fail(volt_mon_fail),
  .dc24_1_fail(dc24_1_fail), .dc24_2_fail(dc24_2_fail),
  .manual_reset_btn(manual_reset_btn), .addr(addr), .rd_en(rd_en),
  .rdata(rdata), .flash_cmd(flash_cmd), .stop_time(stop_time),
  .fault_led(fault_led), .monitor_ok(monitor_ok));
`default_nettype wire

// >>> testbench/scm_timer_model.sv
// Timer unit model facing the monitor's fault outputs
`default_nettype none
module scm_timer_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic stop_time,
  input wire logic flash_cmd,
  input wire logic monitor_ok,
  output logic [7:0] tmr_cnt,
  output logic flash_on
);
  timeunit 1ns;
  timeprecision 1ps;
  // Interval timing freezes while stop time stands
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tmr_cnt <= 8'h00;
    end else if (!stop_time) begin
      tmr_cnt <= tmr_cnt + 8'h01;
    end
  end
  // A missing or unpowered monitor is treated as a fault
  assign flash_on = flash_cmd | ~monitor_ok;
endmodule : scm_timer_model
`default_nettype wire

// >>> testbench/tb.sv
// Self-checking bench for the signal conflict monitor
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin \
  miscompares++; $display("BAD %s exp %h seen %h", n, e, g); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, reset = 1, red_enable = 0, volt = 0, dc1 = 0, dc2 = 0;
  logic btn = 0, wr_en = 0, rd_en = 0, flash_cmd, stop_time, fault_led;
  logic monitor_ok, irq, flash_on;
  logic [scm_pkg::NUM_CH-1:0] ch_red = '0, ch_yellow = '0, ch_green = '0;
  logic [31:0] tod_date = '0, wdata = '0, rdata;
  logic [7:0] addr = '0, tmr_cnt, t0;
  logic [3:0] f;
  int miscompares = 0, num_checks = 0;
  // Clock
  always #5 clk = ~clk;
  scm_monitor uut (.clk(clk), .reset(reset), .ch_red(ch_red),
    .ch_yellow(ch_yellow), .ch_green(ch_green), .red_enable(red_enable),
    .volt_mon_fail(volt), .dc24_1_fail(dc1), .dc24_2_fail(dc2),
    .manual_reset_btn(btn), .tod_date(tod_date), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .flash_cmd(flash_cmd), .stop_time(stop_time), .fault_led(fault_led),
    .monitor_ok(monitor_ok), .irq(irq));
  scm_timer_model tmr (.clk(clk), .reset(reset), .stop_time(stop_time),
    .flash_cmd(flash_cmd), .monitor_ok(monitor_ok), .tmr_cnt(tmr_cnt),
    .flash_on(flash_on));
  // ------------------------------------------------------------------
  // Bus and timing helpers
  // ------------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    `CHK("rdata", e, rdata)
  endtask : rd
  task automatic press();
    @(posedge clk);
    btn <= 1'b1;
    @(posedge clk);
    btn <= 1'b0;
    tick(2);
  endtask : press
  // Bounded wait; a hang ends the run as a failure
  task automatic wait_flash(input logic v);
    int n;
    n = 0;
    // Step off the edge so the latch output is settled when looked at
    #1;
    while (flash_cmd !== v && n < 8) begin
      tick(1);
      n++;
    end
    `CHK("flash_cmd", v, flash_cmd)
    if (flash_cmd !== v) end_of_test();
  endtask : wait_flash
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_of_test
  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    tick(2);
    `CHK("flash_on", 1'b1, flash_on)
    @(posedge clk);
    reset <= 1'b0;
    tick(1);
    `CHK("monitor_ok", 1'b1, monitor_ok)
    rd(scm_pkg::REG_CHAN_USE, 32'hFFF);
    rd(scm_pkg::REG_IRQ_MASK, 32'h0);
    rd(8'hFC, 32'h0);
    wr(scm_pkg::REG_STATUS, 32'hFF);
    rd(scm_pkg::REG_STATUS, 32'h0);
    wr(scm_pkg::REG_CHAN_USE, 32'h00F);
    rd(scm_pkg::REG_CHAN_USE, 32'h00F);
    // Allow channels 0 and 1 together, nothing else
    wr(scm_pkg::REG_COMPAT_BASE, 32'h2);
    wr(8'h44, 32'h1);
    @(posedge clk);
    ch_green <= 12'h003;
    tod_date <= 32'h1234ABCD;
    tick(3);
    `CHK("compatible pair", 1'b0, flash_cmd)
    @(posedge clk);
    ch_yellow <= 12'h004;
    wait_flash(1'b1);
    `CHK("fault_led", 1'b1, fault_led)
    t0 = tmr_cnt;
    tick(5);
    `CHK("timer halted", t0, tmr_cnt)
    `CHK("irq masked", 1'b0, irq)
    wr(scm_pkg::REG_IRQ_MASK, 32'h1);
    tick(2);
    `CHK("irq", 1'b1, irq)
    rd(scm_pkg::REG_CAUSE, 32'h1);
    rd(scm_pkg::REG_CONF_CHAN, 32'h007);
    rd(scm_pkg::REG_LOG_INFO, 32'h101);
    wr(scm_pkg::REG_LOG_IDX, 32'h0);
    rd(scm_pkg::REG_LOG_DATE, 32'h1234ABCD);
    rd(scm_pkg::REG_LOG_CHAN, 32'h007);
    press();
    `CHK("button refused", 1'b1, flash_cmd)
    wr(scm_pkg::REG_IRQ_STAT, 32'h1);
    tick(2);
    `CHK("irq cleared", 1'b0, irq)
    @(posedge clk);
    ch_yellow <= '0;
    ch_green <= '0;
    press();
    wait_flash(1'b0);
    rd(scm_pkg::REG_CAUSE, 32'h0);
    `CHK("timer runs", 1'b1, tmr_cnt !== t0)
    // Each failure input in turn; the last one is a dark channel
    for (int i = 0; i < 4; i++) begin
      f = 4'h1 << i;
      @(posedge clk);
      {red_enable, dc2, dc1, volt} <= f;
      wait_flash(1'b1);
      rd(scm_pkg::REG_CAUSE, 32'h2 << i);
      press();
      `CHK("cause wins", 1'b1, flash_cmd)
      @(posedge clk);
      {red_enable, dc2, dc1, volt} <= 4'h0;
      press();
      wait_flash(1'b0);
    end
    @(posedge clk);
    red_enable <= 1'b1;
    ch_red <= 12'h00F;
    tick(3);
    `CHK("reds lit", 1'b0, flash_cmd)
    @(posedge clk);
    red_enable <= 1'b0;
    ch_red <= '0;
    wr(scm_pkg::REG_IRQ_STAT, 32'h3);
    // Fill the log past its depth so the first record is replaced
    for (int i = 0; i < 128; i++) begin
      @(posedge clk);
      ch_green <= 12'h005;
      repeat (2) @(posedge clk);
      ch_green <= '0;
      @(posedge clk);
    end
    rd(scm_pkg::REG_LOG_INFO, 32'h8001);
    rd(scm_pkg::REG_IRQ_STAT, 32'h3);
    // Only the overwrite bit unmasked, so irq proves the wrap event
    wr(scm_pkg::REG_IRQ_MASK, 32'h2);
    tick(2);
    `CHK("irq wrap", 1'b1, irq)
    rd(scm_pkg::REG_LOG_CHAN, 32'h005);
    end_of_test();
  end
endmodule : tb
`default_nettype wire
